// *** verilog/pesm_top.sv ***
// Event status and interrupt mask registers behind the management serial port
`timescale 1ns/100ps
module pesm_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Receive path and link conditions, same clock
    input wire logic syncLoss,
    input wire logic badSymbol,
    input wire logic startDelimMissing,
    input wire logic endDelimMissing,
    input wire logic polaritySwap,
    input wire logic overlongTx,
    input wire logic linkDown,
    input wire logic rateFastIn,
    input wire logic fullDuplexIn,
    // Address straps, active low
    input wire logic [pesm_pkg::ADDR_W-1:0] phyAddrStrapN,
    // Management serial port
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    // Interrupt
    output logic irqOutN
);
    typedef struct packed {
        pesm_pkg::pesm_mi_state_t fsm;
        logic [pesm_pkg::ONES_W-1:0] onesCnt;
        logic [pesm_pkg::CNT_W-1:0] bitCnt;
        logic [pesm_pkg::HDR_W-1:0] hdr;
        logic [pesm_pkg::DATA_W-1:0] shiftReg;
        logic mdcPrev;
        logic mdioOut;
        logic mdioOe;
        logic [pesm_pkg::ADDR_W-1:0] phyAddr;
        logic [pesm_pkg::MASK_W-1:0] maskBits;
        logic summary;
        logic [1:0] modeChg;
        logic [pesm_pkg::EVT_W+1:0] prevEvt;
        logic rateFastFlag;
        logic fullDuplexFlag;
        logic irqOutN;
    } pesm_top_t;

    pesm_top_t st;
    pesm_top_t next_st;

    logic [pesm_pkg::ADDR_W+1:0] pinSync;
    logic mdcSync;
    logic mdioSync;
    logic [pesm_pkg::ADDR_W-1:0] strapSync;
    logic mdcRise;
    logic readClear;
    logic [pesm_pkg::EVT_W-1:0] eventIn;
    logic [pesm_pkg::EVT_W-1:0] latched;
    logic [pesm_pkg::EVT_W+1:0] evtVec;
    logic anyChange;
    logic [1:0] modeEdge;
    logic [pesm_pkg::MASK_W-1:0] irqSrc;
    logic pending;
    logic [pesm_pkg::DATA_W-1:0] statusWord;
    logic [pesm_pkg::DATA_W-1:0] maskWord;
    logic [pesm_pkg::DATA_W-1:0] dataNew;
    logic [1:0] frmOp;
    logic addrHit;
    logic [pesm_pkg::ADDR_W-1:0] frmReg;

    pesm_sync #(
        .WIDTH(pesm_pkg::ADDR_W + 2)
    ) u_sync (
        .clock(clock),
        .asyncIn({mdc, mdioIn, phyAddrStrapN}),
        .syncOut(pinSync)
    );

    assign mdcSync = pinSync[pesm_pkg::ADDR_W+1];
    assign mdioSync = pinSync[pesm_pkg::ADDR_W];
    assign strapSync = pinSync[pesm_pkg::ADDR_W-1:0];

    assign eventIn[pesm_pkg::EV_LINK] = linkDown;
    assign eventIn[pesm_pkg::EV_SYNC] = syncLoss;
    assign eventIn[pesm_pkg::EV_BADSYM] = badSymbol;
    assign eventIn[pesm_pkg::EV_START] = startDelimMissing;
    assign eventIn[pesm_pkg::EV_END] = endDelimMissing;
    assign eventIn[pesm_pkg::EV_POL] = polaritySwap;
    assign eventIn[pesm_pkg::EV_OVERLONG] = overlongTx;

    pesm_event_latch #(
        .WIDTH(pesm_pkg::EVT_W)
    ) u_latch (
        .clock(clock),
        .rst(rst),
        .eventIn(eventIn),
        .readClear(readClear),
        .flags(latched)
    );

    assign mdcRise = mdcSync & ~st.mdcPrev;

    // Speed and duplex read as the live mode, not latched
    assign statusWord = {st.summary, latched, st.rateFastFlag, st.fullDuplexFlag,
        {pesm_pkg::RSVD_W{1'b0}}};
    assign maskWord = {st.maskBits, {pesm_pkg::RSVD_W{1'b0}}};

    assign evtVec = {latched, st.rateFastFlag, st.fullDuplexFlag};
    assign anyChange = evtVec != st.prevEvt;
    assign modeEdge = evtVec[1:0] ^ st.prevEvt[1:0];

    // Mode changes rather than mode levels drive the two low interrupt sources
    assign irqSrc = {st.summary, latched, st.modeChg};
    assign pending = |(irqSrc & ~st.maskBits);

    assign frmOp = st.hdr[pesm_pkg::OP_MSB:pesm_pkg::OP_LSB];
    assign frmReg = st.hdr[pesm_pkg::REG_MSB:pesm_pkg::REG_LSB];
    assign addrHit = st.hdr[pesm_pkg::PHY_MSB:pesm_pkg::PHY_LSB] == st.phyAddr;
    assign dataNew = {st.shiftReg[pesm_pkg::DATA_W-2:0], mdioSync};

    always_comb
    begin
        next_st = st;
        readClear = 1'b0;
        next_st.mdcPrev = mdcSync;
        next_st.rateFastFlag = rateFastIn;
        next_st.fullDuplexFlag = fullDuplexIn;
        next_st.prevEvt = evtVec;
        case (st.fsm)
            pesm_pkg::MI_PREAMBLE:
            begin
                if (mdcRise)
                begin
                    if (!mdioSync)
                    begin
                        next_st.onesCnt = '0;
                    end
                    else if (st.onesCnt + 1'b1 == pesm_pkg::IDLE_ONES)
                    begin
                        next_st.fsm = pesm_pkg::MI_IDLE;
                    end
                    else
                    begin
                        next_st.onesCnt = st.onesCnt + 1'b1;
                    end
                end
            end
            pesm_pkg::MI_IDLE:
            begin
                if (mdcRise && !mdioSync)
                begin
                    next_st.fsm = pesm_pkg::MI_START;
                end
            end
            pesm_pkg::MI_START:
            begin
                if (mdcRise)
                begin
                    next_st.bitCnt = '0;
                    next_st.onesCnt = '0;
                    next_st.fsm = mdioSync ? pesm_pkg::MI_HEADER : pesm_pkg::MI_PREAMBLE;
                end
            end
            pesm_pkg::MI_HEADER:
            begin
                if (mdcRise)
                begin
                    next_st.hdr = {st.hdr[pesm_pkg::HDR_W-2:0], mdioSync};
                    next_st.bitCnt = st.bitCnt + 1'b1;
                    if (st.bitCnt == pesm_pkg::HDR_LAST)
                    begin
                        next_st.fsm = pesm_pkg::MI_DECIDE;
                    end
                end
            end
            pesm_pkg::MI_DECIDE:
            begin
                // Snapshot and clear share one edge, so no event slips between
                next_st.bitCnt = '0;
                next_st.fsm = pesm_pkg::MI_DATA;
                if (addrHit && frmOp == pesm_pkg::OP_READ)
                begin
                    if (frmReg == pesm_pkg::REG_STATUS)
                    begin
                        next_st.shiftReg = statusWord;
                        next_st.mdioOut = statusWord[pesm_pkg::DATA_W-1];
                        next_st.mdioOe = 1'b1;
                        readClear = 1'b1;
                    end
                    else if (frmReg == pesm_pkg::REG_MASK)
                    begin
                        next_st.shiftReg = maskWord;
                        next_st.mdioOut = maskWord[pesm_pkg::DATA_W-1];
                        next_st.mdioOe = 1'b1;
                    end
                end
            end
            pesm_pkg::MI_DATA:
            begin
                if (mdcRise)
                begin
                    next_st.bitCnt = st.bitCnt + 1'b1;
                    next_st.shiftReg = dataNew;
                    next_st.mdioOut = st.shiftReg[pesm_pkg::DATA_W-2];
                    if (st.bitCnt == pesm_pkg::DATA_LAST)
                    begin
                        // Another frame needs a fresh run of idle ones
                        next_st.mdioOe = 1'b0;
                        next_st.mdioOut = 1'b0;
                        next_st.onesCnt = '0;
                        next_st.fsm = pesm_pkg::MI_PREAMBLE;
                        if (addrHit && frmOp == pesm_pkg::OP_WRITE &&
                            frmReg == pesm_pkg::REG_MASK && !st.mdioOe)
                        begin
                            next_st.maskBits = dataNew[pesm_pkg::DATA_W-1:pesm_pkg::MASK_LSB];
                        end
                    end
                end
            end
            default:
            begin
                next_st.fsm = pesm_pkg::MI_PREAMBLE;
            end
        endcase
        next_st.summary = anyChange | (st.summary & ~readClear);
        next_st.modeChg = modeEdge | (st.modeChg & {2{~readClear}});
        next_st.irqOutN = ~pending;
        if (rst)
        begin
            next_st.fsm = pesm_pkg::MI_PREAMBLE;
            next_st.onesCnt = '0;
            next_st.bitCnt = '0;
            next_st.hdr = '0;
            next_st.shiftReg = '0;
            next_st.mdcPrev = 1'b0;
            next_st.mdioOut = 1'b0;
            next_st.mdioOe = 1'b0;
            // Straps are read inverted while reset is held
            next_st.phyAddr = ~strapSync;
            next_st.maskBits = pesm_pkg::MASK_RESET[pesm_pkg::DATA_W-1:pesm_pkg::MASK_LSB];
            next_st.summary = 1'b0;
            next_st.modeChg = '0;
            next_st.prevEvt = {{pesm_pkg::EVT_W{1'b0}}, pesm_pkg::RATE_RESET,
                pesm_pkg::DUPLEX_RESET};
            next_st.rateFastFlag = pesm_pkg::RATE_RESET;
            next_st.fullDuplexFlag = pesm_pkg::DUPLEX_RESET;
            next_st.irqOutN = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        st <= next_st;
    end

    assign mdioOut = st.mdioOut;
    assign mdioOe = st.mdioOe;
    assign irqOutN = st.irqOutN;

    default clocking cb @(posedge clock);
    endclocking

    default disable iff (rst);

    chk_sync_latch: assert property (syncLoss |=> latched[pesm_pkg::EV_SYNC])
        else $error("sync loss not latched");

    chk_code_latch: assert property (badSymbol |=> latched[pesm_pkg::EV_BADSYM])
        else $error("invalid code not latched");

    chk_start_latch: assert property (
        startDelimMissing |=> statusWord[pesm_pkg::EV_START + 8])
        else $error("start delimiter error not latched");

    chk_end_latch: assert property (
        endDelimMissing |=> statusWord[pesm_pkg::EV_END + 8])
        else $error("end delimiter error not latched");

    chk_polarity_irq: assert property (
        polaritySwap && !st.maskBits[pesm_pkg::MK_POL] && !$changed(st.maskBits)
        |-> ##2 !irqOutN)
        else $error("unmasked polarity event gave no interrupt");

    chk_jabber_irq: assert property (
        overlongTx && !st.maskBits[pesm_pkg::MK_OVERLONG] && !$changed(st.maskBits)
        |-> ##2 !irqOutN)
        else $error("unmasked jabber event gave no interrupt");

    chk_speed_follow: assert property (rateFastIn |=> statusWord[7])
        else $error("speed bit does not follow mode");

    chk_duplex_follow: assert property (!fullDuplexIn |=> !statusWord[6])
        else $error("duplex bit does not follow mode");

    chk_mask_reset: assert property (
        disable iff (1'b0) rst |=> maskWord == pesm_pkg::MASK_RESET)
        else $error("mask register reset value wrong");

    chk_all_masked: assert property (
        (&st.maskBits) [*2] |=> irqOutN)
        else $error("interrupt raised while every source masked");

    chk_summary_set: assert property (anyChange |=> st.summary [*1] or readClear)
        else $error("change flag not set on event change");

    chk_flags_hold: assert property (
        !readClear |=> (latched & $past(latched)) == $past(latched))
        else $error("latched flag dropped without a status read");

    // A status read may empty every source in the cycle the pin falls
    chk_irq_level: assert property (pending |=> !irqOutN)
        else $error("interrupt output does not track pending sources");

    chk_irq_idle: assert property (!pending |=> irqOutN)
        else $error("interrupt asserted with nothing pending");

    cov_status_read: cover property (readClear ##[1:1000] !mdioOe);
    cov_mask_write: cover property (st.maskBits != $past(st.maskBits) && !$past(rst));
    cov_irq_assert: cover property ($fell(irqOutN));
endmodule

// *** verilog/pesm_pkg.sv ***
// Constants, field layout and state encoding for the event status and mask block
package pesm_pkg;
    localparam logic [4:0] REG_STATUS = 5'h12;
    localparam logic [4:0] REG_MASK = 5'h13;
    localparam logic [15:0] MASK_RESET = 16'hFFC0;
    localparam int MASK_LSB = 6;
    localparam int MASK_W = 10;
    localparam int RSVD_W = 6;
    localparam int EVT_W = 7;
    localparam int ADDR_W = 5;
    localparam int HDR_W = 14;
    localparam int DATA_W = 16;
    localparam int CNT_W = 5;
    localparam int ONES_W = 6;
    localparam logic [5:0] IDLE_ONES = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0D;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam int OP_MSB = 13;
    localparam int OP_LSB = 12;
    localparam int PHY_MSB = 11;
    localparam int PHY_LSB = 7;
    localparam int REG_MSB = 6;
    localparam int REG_LSB = 2;
    localparam logic RATE_RESET = 1'b1;
    localparam logic DUPLEX_RESET = 1'b0;
    localparam int EV_LINK = 6;
    localparam int EV_SYNC = 5;
    localparam int EV_BADSYM = 4;
    localparam int EV_START = 3;
    localparam int EV_END = 2;
    localparam int EV_POL = 1;
    localparam int EV_OVERLONG = 0;
    localparam int MK_SUMMARY = 9;
    localparam int MK_POL = 3;
    localparam int MK_OVERLONG = 2;

    typedef enum logic [5:0] {
        MI_PREAMBLE = 6'h01,
        MI_IDLE = 6'h02,
        MI_START = 6'h04,
        MI_HEADER = 6'h08,
        MI_DECIDE = 6'h10,
        MI_DATA = 6'h20
    } pesm_mi_state_t;
endpackage

// *** verilog/pesm_sync.sv ***
// Two-stage synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/100ps
module pesm_sync #(
    parameter int WIDTH = 7
) (
    // Clock
    input wire logic clock,
    // Pins and their synchronised copies
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } pesm_sync_t;

    pesm_sync_t st;
    pesm_sync_t next_st;

    // No reset: straps must survive reset so they can be captured during it
    always_comb
    begin
        next_st = st;
        next_st.stage1 = asyncIn;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clock)
    begin
        st <= next_st;
    end

    assign syncOut = st.stage2;
endmodule

// *** verilog/pesm_event_latch.sv ***
// Latch-high event flags that fall back to the live condition when read
`timescale 1ns/100ps
module pesm_event_latch #(
    parameter int WIDTH = pesm_pkg::EVT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Conditions and read strobe
    input wire logic [WIDTH-1:0] eventIn,
    input wire logic readClear,
    // Latched flags
    output logic [WIDTH-1:0] flags
);
    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } pesm_latch_t;

    pesm_latch_t st;
    pesm_latch_t next_st;
    logic [WIDTH-1:0] setTerm;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_flag
            // A condition present in the read cycle wins over the clear
            assign setTerm[i] = eventIn[i] | (st.flags[i] & ~readClear);
        end
    endgenerate

    always_comb
    begin
        next_st = st;
        next_st.flags = setTerm;
        if (rst)
        begin
            next_st.flags = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        st <= next_st;
    end

    assign flags = st.flags;

    chk_read_reloads: assert property (
        @(posedge clock) disable iff (rst)
        readClear |=> flags == $past(eventIn))
        else $error("flag did not take live condition after read");

    cov_read_with_event: cover property (
        @(posedge clock) disable iff (rst)
        readClear && (eventIn != '0));
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the event status and interrupt mask block over its serial port
`timescale 1ns/100ps
`define CHK(got, exp) compare(got, exp)

module tb_top;
    localparam int HALF = 6;
    localparam logic [4:0] PHY_ADDR = 5'h05;

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [6:0] ev = 7'h00;
    logic rateFastIn = 1'b1;
    logic fullDuplexIn = 1'b0;
    logic mdc = 1'b0;
    logic masterDrive = 1'b1;
    logic masterOe = 1'b1;
    logic mdioOut;
    logic mdioOe;
    logic irqOutN;
    wire logic mdioLine;
    int errorCnt = 0;
    int checks = 0;
    logic [15:0] rd;
    logic [15:0] bitSel;

    // The serial data line has a pull-up, so a released line reads one
    assign mdioLine = masterOe ? masterDrive : (mdioOe ? mdioOut : 1'b1);

    always #5 clock = ~clock;

    pesm_top DUT (
        .clock(clock),
        .rst(rst),
        .syncLoss(ev[5]),
        .badSymbol(ev[4]),
        .startDelimMissing(ev[3]),
        .endDelimMissing(ev[2]),
        .polaritySwap(ev[1]),
        .overlongTx(ev[0]),
        .linkDown(ev[6]),
        .rateFastIn(rateFastIn),
        .fullDuplexIn(fullDuplexIn),
        .phyAddrStrapN(~PHY_ADDR),
        .mdc(mdc),
        .mdioIn(mdioLine),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe),
        .irqOutN(irqOutN)
    );

    task automatic final_report();
        $display("checks %0d errors %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One management clock period; the line is sampled just before the rising edge
    task automatic mdc_cycle(input logic d, input logic drive, output logic smp);
        masterDrive = d;
        masterOe = drive;
        tick(HALF);
        smp = mdioLine;
        mdc = 1'b1;
        tick(HALF);
        mdc = 1'b0;
    endtask

    // Whole frame: idle ones, start pattern, header, then sixteen data bits
    task automatic mi_frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                            input logic [15:0] wdata, output logic [15:0] rdata);
        logic [13:0] hdr;
        logic smp;
        logic wr;
        wr = (op == pesm_pkg::OP_WRITE);
        hdr = {op, phy, regad, 2'b10};
        for (int i = 0; i < 32; i++)
            mdc_cycle(1'b1, 1'b1, smp);
        mdc_cycle(1'b0, 1'b1, smp);
        mdc_cycle(1'b1, 1'b1, smp);
        // A read releases the line from the turnaround bits on
        for (int i = 13; i >= 0; i--)
            mdc_cycle(hdr[i], wr || i > 1, smp);
        for (int i = 15; i >= 0; i--)
        begin
            mdc_cycle(wdata[i], wr, smp);
            rdata[i] = smp;
        end
        masterDrive = 1'b1;
        masterOe = 1'b1;
    endtask

    task automatic rd_reg(input logic [4:0] regad, output logic [15:0] data);
        mi_frame(pesm_pkg::OP_READ, PHY_ADDR, regad, 16'hFFFF, data);
    endtask

    task automatic wr_reg(input logic [4:0] regad, input logic [15:0] data);
        logic [15:0] dummy;
        mi_frame(pesm_pkg::OP_WRITE, PHY_ADDR, regad, data, dummy);
    endtask

    task automatic pulse(input int b);
        ev[b] = 1'b1;
        tick(1);
        ev[b] = 1'b0;
    endtask

    // Bounded wait for the interrupt to fall; a miss ends the run
    task automatic irq_wait();
        int n;
        n = 0;
        while (irqOutN !== 1'b0 && n < 8)
        begin
            tick(1);
            n++;
        end
        `CHK({15'h0000, irqOutN}, 16'h0000);
        if (irqOutN !== 1'b0)
        begin
            final_report();
        end
    endtask

    initial
    begin
        tick(16);
        rst = 1'b0;
        tick(2);
        rd_reg(pesm_pkg::REG_STATUS, rd);
        `CHK(rd, 16'h0080);
        rd_reg(pesm_pkg::REG_MASK, rd);
        `CHK(rd, pesm_pkg::MASK_RESET);
        `CHK({15'h0000, irqOutN}, 16'h0001);
        // Masked events latch, hold across the wait, and fall back once read
        for (int b = 0; b < 7; b++)
        begin
            bitSel = 16'h0100 << b;
            pulse(b);
            tick(4);
            `CHK({15'h0000, irqOutN}, 16'h0001);
            rd_reg(pesm_pkg::REG_STATUS, rd);
            `CHK(rd, 16'h8080 | bitSel);
            rd_reg(pesm_pkg::REG_STATUS, rd);
            `CHK(rd & 16'h7FFF, 16'h0080);
        end
        // Each event alone unmasked drives the interrupt until the status read
        for (int b = 0; b < 7; b++)
        begin
            bitSel = 16'h0100 << b;
            wr_reg(pesm_pkg::REG_MASK, pesm_pkg::MASK_RESET & ~bitSel);
            pulse(b);
            irq_wait();
            rd_reg(pesm_pkg::REG_STATUS, rd);
            `CHK(rd & 16'h7FFF, 16'h0080 | bitSel);
            tick(4);
            `CHK({15'h0000, irqOutN}, 16'h0001);
        end
        wr_reg(pesm_pkg::REG_MASK, 16'hFFFF);
        rd_reg(pesm_pkg::REG_MASK, rd);
        `CHK(rd, 16'hFFC0);
        wr_reg(pesm_pkg::REG_MASK, 16'hAA80);
        rd_reg(pesm_pkg::REG_MASK, rd);
        `CHK(rd, 16'hAA80);
        // Speed change
        wr_reg(pesm_pkg::REG_MASK, 16'hFF40);
        rateFastIn = 1'b0;
        irq_wait();
        rd_reg(pesm_pkg::REG_STATUS, rd);
        `CHK(rd, 16'h8000);
        tick(4);
        `CHK({15'h0000, irqOutN}, 16'h0001);
        wr_reg(pesm_pkg::REG_MASK, pesm_pkg::MASK_RESET);
        rateFastIn = 1'b1;
        // Duplex change
        wr_reg(pesm_pkg::REG_MASK, 16'hFF80);
        fullDuplexIn = 1'b1;
        irq_wait();
        rd_reg(pesm_pkg::REG_STATUS, rd);
        `CHK(rd, 16'h80C0);
        tick(4);
        `CHK({15'h0000, irqOutN}, 16'h0001);
        wr_reg(pesm_pkg::REG_MASK, pesm_pkg::MASK_RESET);
        fullDuplexIn = 1'b0;
        rd_reg(pesm_pkg::REG_STATUS, rd);
        `CHK(rd, 16'h8080);
        // Summary flag as the only unmasked source
        wr_reg(pesm_pkg::REG_MASK, 16'h7FC0);
        pulse(5);
        irq_wait();
        rd_reg(pesm_pkg::REG_STATUS, rd);
        `CHK(rd, 16'hA080);
        wr_reg(pesm_pkg::REG_MASK, pesm_pkg::MASK_RESET);
        rd_reg(pesm_pkg::REG_STATUS, rd);
        // Refused accesses leave the registers alone and the line released
        wr_reg(pesm_pkg::REG_STATUS, 16'hFFC0);
        rd_reg(pesm_pkg::REG_STATUS, rd);
        `CHK(rd & 16'h7FFF, 16'h0080);
        mi_frame(pesm_pkg::OP_READ, PHY_ADDR ^ 5'h01, pesm_pkg::REG_MASK, 16'hFFFF, rd);
        `CHK(rd, 16'hFFFF);
        `CHK({15'h0000, mdioOe}, 16'h0000);
        mi_frame(pesm_pkg::OP_WRITE, PHY_ADDR ^ 5'h01, pesm_pkg::REG_MASK, 16'h0000, rd);
        rd_reg(pesm_pkg::REG_MASK, rd);
        `CHK(rd, pesm_pkg::MASK_RESET);
        final_report();
    end
endmodule
